/* core/ppc_nv_image.sv */
`timescale 1ns/1ps
`default_nettype none

// byte image of variable memory held in permanent storage
module ppc_nv_image (
	input  wire logic                      core_clk,
	input  wire logic                      clk_en,
	input  wire logic                      we,
	input  wire logic [ppc_pkg::NV_AW-1:0] waddr,
	input  wire logic [ppc_pkg::NV_DW-1:0] wdata,
	input  wire logic [ppc_pkg::NV_AW-1:0] raddr,
	output logic      [ppc_pkg::NV_DW-1:0] rdata
);

	logic [ppc_pkg::NV_DW-1:0] mem_reg [2**ppc_pkg::NV_AW];

	always_ff @(posedge core_clk) begin
		if (clk_en && we) begin
			mem_reg[waddr] <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (clk_en) begin
			rdata <= mem_reg[raddr];
		end
	end

endmodule

`default_nettype wire

/* core/ppc_persistence_ctrl.sv */
// Behaviour
// R1 - software loads source address into save_address_word before requesting
// R2 - save size bits: 1 byte, 2 word, 3 double word
// R3 - at each scan end, a set request bit starts the copy
// R4 - device clears save_request_bit when copy is done; sole completion sign
// R5 - software keeps source data unchanged while request bit is set
// R6 - completed save overwrites the permanent image at that address
// R7 - a program save never touches the cartridge
// R8 - a save lengthens its scan by about 10 to 15 ms
// R9 - software saves only on rare events, memory wears out
// R10 - power-up reloads program and system blocks, then checks kept RAM
// R11 - RAM kept: retentive stays, V reloaded, other non-retentive zeroed
// R12 - RAM lost: zero all, flag loss, reload V, restore retentive bytes
// R13 - power loss saves retentive first 14 bit-memory bytes
// R14 - differing cartridge at power-up: copy all its blocks in
// R15 - cartridge data block: replace, clear V, init V from it
// R16 - cartridge system block: replace with forces, clear retentive areas
// R17 - cartridge writing only allowed while stopped
// R18 - host erases cartridge program elements before copying
// R19 - accept lower-model cartridge, reject higher-model one with error
// R20 - switch stop halts, run starts, remote keeps mode
// R21 - after power cycle: stop or remote gives stop, run gives run
// R22 - host mode commands only with switch at remote or run
// R23 - cartridge work finishes before run entry is evaluated
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module ppc_persistence_ctrl #(
	parameter int         SAVE_CYC    = ppc_pkg::SAVE_CYCLES,
	parameter logic [3:0] MODEL_LEVEL = 4'h2
) (
	input  wire logic                       core_clk,
	input  wire logic                       srst,
	input  wire logic                       clk_en,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [ppc_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [1:0]                 mode_sw_pin,
	input  wire logic                       power_fail_pin,
	input  wire logic                       cart_present_pin,
	input  wire logic                       cart_differs,
	input  wire logic                       cart_has_prog,
	input  wire logic                       cart_has_data,
	input  wire logic                       cart_has_sys,
	input  wire logic [3:0]                 cart_model,
	input  wire logic                       ram_kept,
	input  wire logic                       scan_end,
	output logic      [15:0]                vmem_addr,
	output logic                            vmem_rd,
	input  wire logic [7:0]                 vmem_rdata,
	output logic      [3:0]                 op_code,
	output logic                            op_start,
	output logic      [13:0]                op_arg,
	input  wire logic                       op_done,
	output logic                            run_mode,
	output logic                            scan_hold,
	output logic                            cart_prog_en,
	output logic                            data_lost_flag,
	output logic                            cart_error,
	output logic                            powerup_done
);

	typedef enum logic [3:0] {
		PU_CART_CHK, PU_CART_PROG, PU_CART_DB, PU_CLR_V, PU_INIT_V,
		PU_CART_SYS, PU_CLR_RET, PU_BLOCKS, PU_RAM_CHK, PU_KEEP, PU_ZERO,
		PU_LOST_V, PU_LOST_MB, PU_DONE, PU_PF_SAVE, PU_HALT
	} ppc_pu_t;

	localparam logic [ppc_pkg::TMR_W-1:0] TMR_LAST =
		ppc_pkg::TMR_W'(SAVE_CYC - 1);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sw_m_reg, sw_s_reg, sw_d_reg;
	logic       pf_m_reg, pf_s_reg, pf_d_reg;
	logic       cp_m_reg, cp_s_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sw_m_reg <= 2'h0;
			sw_s_reg <= 2'h0;
			sw_d_reg <= 2'h0;
			pf_m_reg <= 1'b0;
			pf_s_reg <= 1'b0;
			pf_d_reg <= 1'b0;
			cp_m_reg <= 1'b0;
			cp_s_reg <= 1'b0;
		end else if (clk_en) begin
			sw_m_reg <= mode_sw_pin;
			sw_s_reg <= sw_m_reg;
			sw_d_reg <= sw_s_reg;
			pf_m_reg <= power_fail_pin;
			pf_s_reg <= pf_m_reg;
			pf_d_reg <= pf_s_reg;
			cp_m_reg <= cart_present_pin;
			cp_s_reg <= cp_m_reg;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic        save_req_reg, save_busy_reg, cart_req_reg;
	logic [1:0]  save_size_reg;
	logic [15:0] save_addr_reg;
	logic [13:0] retain_reg;
	logic [ppc_pkg::NV_AW-1:0] peek_addr_reg;
	logic [ppc_pkg::NV_DW-1:0] nv_rdata;
	logic        run_reg, pu_done_reg, lost_reg, cerr_reg;
	logic [31:0] rd_mux;
	logic        hit, wr_en, wr_ctrl, wr_ctrl_set, wr_mode, save_done;
	logic [7:0]  idx;

	assign idx         = paddr[9:2];
	assign wr_en       = psel && penable && pwrite && pready;
	assign wr_ctrl     = wr_en && idx == ppc_pkg::SAVE_CTRL_IDX;
	assign wr_ctrl_set = wr_ctrl && pwdata[ppc_pkg::REQ_BIT];
	assign wr_mode     = wr_en && idx == ppc_pkg::MODE_IDX;

	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else begin
			unique case (idx)
			ppc_pkg::SAVE_CTRL_IDX: rd_mux[7:0] =
				{save_req_reg, 5'h00, save_size_reg};
			ppc_pkg::SAVE_ADDR_IDX: rd_mux[15:0] = save_addr_reg;
			ppc_pkg::MODE_IDX: rd_mux[11:0] = {save_busy_reg, cerr_reg,
				lost_reg, pu_done_reg, 2'h0, sw_s_reg, 1'b0,
				cart_req_reg, 1'b0, run_reg};
			ppc_pkg::RETAIN_IDX: rd_mux[13:0] = retain_reg;
			ppc_pkg::PEEK_IDX: rd_mux[7:0] = nv_rdata;
			default: hit = 1'b0;
			endcase
		end
	end

	// read data is fetched in the setup cycle so pready can stay high
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= 1'b1;
			if (psel && !penable) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= !hit;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			save_size_reg <= ppc_pkg::SAVE_SIZE_RST;
			save_addr_reg <= ppc_pkg::SAVE_ADDR_RST;
			retain_reg    <= ppc_pkg::RETAIN_RST;
			peek_addr_reg <= '0;
			cart_req_reg  <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl) begin
				save_size_reg <= pwdata[1:0]; // [R2]
			end
			if (wr_en && idx == ppc_pkg::SAVE_ADDR_IDX) begin
				save_addr_reg <= pwdata[15:0]; // [R1]
			end
			if (wr_en && idx == ppc_pkg::RETAIN_IDX) begin
				retain_reg <= pwdata[13:0];
			end
			if (wr_en && idx == ppc_pkg::PEEK_IDX) begin
				peek_addr_reg <= pwdata[ppc_pkg::NV_AW-1:0];
			end
			if (wr_mode) begin
				cart_req_reg <= pwdata[ppc_pkg::MODE_CART_BIT];
			end
		end
	end

	// set from software wins over the device's own clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			save_req_reg <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl_set) begin
				save_req_reg <= 1'b1;
			end else if (save_done || (wr_ctrl && !save_busy_reg)) begin
				save_req_reg <= 1'b0; // [R4]
			end
		end
	end

	// ----------------------------------------------------------------
	// save engine
	// ----------------------------------------------------------------
	logic [2:0]  sidx_reg, nbytes;
	logic        rd_wr_reg, save_start, halted;
	logic [15:0] src_addr;
	logic [ppc_pkg::TMR_W-1:0] save_tmr_reg;

	always_comb begin
		unique case (save_size_reg)
		ppc_pkg::SIZE_BYTE:  nbytes = 3'h1; // [R2]
		ppc_pkg::SIZE_WORD:  nbytes = 3'h2;
		ppc_pkg::SIZE_DWORD: nbytes = 3'h4;
		default:             nbytes = 3'h0;
		endcase
	end

	assign src_addr   = save_addr_reg + {13'h0000, sidx_reg};
	assign save_start = scan_end && save_req_reg && !save_busy_reg
		&& pu_done_reg && !halted; // [R3]
	// hold the scan for the full figure even for one byte
	assign save_done  = save_busy_reg && !vmem_rd && !rd_wr_reg
		&& sidx_reg == nbytes
		&& (nbytes == 3'h0 || save_tmr_reg >= TMR_LAST); // [R8]

	always_ff @(posedge core_clk) begin
		if (srst) begin
			save_busy_reg <= 1'b0;
			sidx_reg      <= 3'h0;
			rd_wr_reg     <= 1'b0;
			save_tmr_reg  <= '0;
			vmem_rd       <= 1'b0;
			vmem_addr     <= 16'h0000;
		end else if (clk_en) begin
			rd_wr_reg <= vmem_rd;
			vmem_rd   <= 1'b0;
			if (save_start) begin
				save_busy_reg <= 1'b1;
				sidx_reg      <= 3'h0;
				save_tmr_reg  <= '0;
			end else if (save_done) begin
				save_busy_reg <= 1'b0;
			end else if (save_busy_reg) begin
				if (save_tmr_reg != TMR_LAST) begin
					save_tmr_reg <= save_tmr_reg + 1'b1;
				end
				if (rd_wr_reg) begin
					sidx_reg <= sidx_reg + 3'h1;
				end else if (!vmem_rd && sidx_reg != nbytes) begin
					vmem_rd   <= 1'b1;
					vmem_addr <= src_addr;
				end
			end
		end
	end

	// write lands on the same address in the image, replacing old data
	ppc_nv_image u_image (
		.core_clk (core_clk),
		.clk_en   (clk_en),
		.we       (rd_wr_reg),
		.waddr    (src_addr[ppc_pkg::NV_AW-1:0]),
		.wdata    (vmem_rdata),
		.raddr    (peek_addr_reg),
		.rdata    (nv_rdata)
	); // [R6]

	assign scan_hold = save_busy_reg;

	// ----------------------------------------------------------------
	// power-up, cartridge and power-loss sequencer
	// ----------------------------------------------------------------
	ppc_pu_t         pu_reg, step_next;
	ppc_pkg::ppc_op_t step_op;
	logic            op_busy_reg, cart_ok;
	logic [1:0]      settle_reg;

	function automatic ppc_pu_t cart_pick(input logic p, d, s);
		if (p) return PU_CART_PROG;
		if (d) return PU_CART_DB;
		if (s) return PU_CART_SYS;
		return PU_BLOCKS;
	endfunction

	assign halted  = pu_reg == PU_PF_SAVE || pu_reg == PU_HALT;
	assign cart_ok = cp_s_reg && cart_differs
		&& cart_model <= MODEL_LEVEL; // [R19]

	always_comb begin
		step_op   = ppc_pkg::OP_NONE;
		step_next = pu_reg;
		unique case (pu_reg)
		PU_CART_PROG: begin
			step_op   = ppc_pkg::OP_CART_PROG; // [R14]
			step_next = cart_pick(1'b0, cart_has_data, cart_has_sys);
		end
		PU_CART_DB: begin
			step_op   = ppc_pkg::OP_CART_DB; // [R15]
			step_next = PU_CLR_V;
		end
		PU_CLR_V: begin
			step_op   = ppc_pkg::OP_CLEAR_V;
			step_next = PU_INIT_V;
		end
		PU_INIT_V: begin
			step_op   = ppc_pkg::OP_INIT_V;
			step_next = cart_pick(1'b0, 1'b0, cart_has_sys);
		end
		PU_CART_SYS: begin
			step_op   = ppc_pkg::OP_CART_SYS; // [R16]
			step_next = PU_CLR_RET;
		end
		PU_CLR_RET: begin
			step_op   = ppc_pkg::OP_CLEAR_RET;
			step_next = PU_BLOCKS;
		end
		PU_BLOCKS: begin
			step_op   = ppc_pkg::OP_LOAD_BLOCKS; // [R10]
			step_next = PU_RAM_CHK;
		end
		PU_KEEP: begin
			step_op   = ppc_pkg::OP_KEEP_RELOAD; // [R11]
			step_next = PU_DONE;
		end
		PU_ZERO: begin
			step_op   = ppc_pkg::OP_ZERO_ALL; // [R12]
			step_next = PU_LOST_V;
		end
		PU_LOST_V: begin
			step_op   = ppc_pkg::OP_INIT_V;
			step_next = retain_reg != 14'h0000 ? PU_LOST_MB : PU_DONE;
		end
		PU_LOST_MB: begin
			step_op   = ppc_pkg::OP_RESTORE_MB;
			step_next = PU_DONE;
		end
		PU_PF_SAVE: begin
			step_op   = ppc_pkg::OP_SAVE_MB; // [R13]
			step_next = PU_HALT;
		end
		default: begin
		end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pu_reg      <= PU_CART_CHK;
			settle_reg  <= 2'h0;
			op_busy_reg <= 1'b0;
			op_start    <= 1'b0;
			op_code     <= 4'h0;
			op_arg      <= 14'h0000;
			cerr_reg    <= 1'b0;
		end else if (clk_en) begin
			op_start <= 1'b0;
			if (pf_s_reg && !pf_d_reg && !halted) begin
				// an op in flight is abandoned, power is going
				op_busy_reg <= 1'b0;
				pu_reg <= retain_reg != 14'h0000 ? PU_PF_SAVE : PU_HALT;
			end else if (pu_reg == PU_CART_CHK) begin
				// wait for the synchronised pins to settle
				if (settle_reg != 2'h3) begin
					settle_reg <= settle_reg + 2'h1;
				end else begin
					cerr_reg <= cp_s_reg && cart_model > MODEL_LEVEL;
					pu_reg   <= cart_ok ? cart_pick(cart_has_prog,
						cart_has_data, cart_has_sys) : PU_BLOCKS; // [R23]
				end
			end else if (pu_reg == PU_RAM_CHK) begin
				pu_reg <= ram_kept ? PU_KEEP : PU_ZERO; // [R10]
			end else if (step_op != ppc_pkg::OP_NONE) begin
				if (!op_busy_reg) begin
					op_busy_reg <= 1'b1;
					op_start    <= 1'b1;
					op_code     <= 4'(step_op);
					op_arg      <= retain_reg;
				end else if (op_done && !op_start) begin
					op_busy_reg <= 1'b0;
					pu_reg      <= step_next;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// mode and status
	// ----------------------------------------------------------------
	logic host_ok, run_going;

	assign host_ok = sw_s_reg != ppc_pkg::SW_STOP; // [R22]
	// anything that may raise run at the next edge blocks the cartridge now
	assign run_going = (sw_s_reg != sw_d_reg
		&& sw_s_reg == ppc_pkg::SW_RUN)
		|| (wr_mode && host_ok && pwdata[ppc_pkg::MODE_RUN_BIT]);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			run_reg     <= 1'b0;
			pu_done_reg <= 1'b0;
		end else if (clk_en) begin
			if (halted) begin
				run_reg     <= 1'b0;
				pu_done_reg <= 1'b0;
			end else if (!pu_done_reg) begin
				if (pu_reg == PU_DONE) begin
					pu_done_reg <= 1'b1;
					run_reg     <= sw_s_reg == ppc_pkg::SW_RUN; // [R21]
				end
			end else if (sw_s_reg != sw_d_reg
				&& sw_s_reg == ppc_pkg::SW_STOP) begin
				run_reg <= 1'b0; // [R20]
			end else if (sw_s_reg != sw_d_reg
				&& sw_s_reg == ppc_pkg::SW_RUN) begin
				run_reg <= 1'b1; // [R20]
			end else if (wr_mode && host_ok) begin
				if (pwdata[ppc_pkg::MODE_STOP_BIT]) begin
					run_reg <= 1'b0; // [R22]
				end else if (pwdata[ppc_pkg::MODE_RUN_BIT]) begin
					run_reg <= 1'b1; // [R22]
				end
			end
		end
	end

	// loss flag: power-up sets it, software clears, set wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lost_reg <= 1'b0;
		end else if (clk_en) begin
			if (pu_reg == PU_ZERO && op_busy_reg && op_done) begin
				lost_reg <= 1'b1; // [R12]
			end else if (wr_mode && pwdata[ppc_pkg::MODE_LOST_BIT]) begin
				lost_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cart_prog_en <= 1'b0;
		end else if (clk_en) begin
			cart_prog_en <= cart_req_reg && !run_reg && !run_going
				&& !save_busy_reg && !save_start
				&& pu_done_reg && cp_s_reg; // [R7] [R17]
		end
	end

	assign run_mode       = run_reg;
	assign powerup_done   = pu_done_reg;
	assign data_lost_flag = lost_reg;
	assign cart_error     = cerr_reg;

	// ----------------------------------------------------------------
	// checks (valid while clk_en stays high)
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_fetch;
		vmem_rd ##1 rd_wr_reg && src_addr == $past(vmem_addr);
	endsequence
	property p_copy_path;
		vmem_rd |-> s_fetch;
	endproperty
	a_copy_path: assert property (p_copy_path) // [R6]
		else $error("fetched byte not written to image");

	property p_start;
		clk_en && save_start |=> save_busy_reg && scan_hold;
	endproperty
	a_start: assert property (p_start) // [R3]
		else $error("save request not taken at scan end");

	property p_min_time;
		$fell(save_busy_reg) && $past(nbytes) != 3'h0
			|-> $past(save_tmr_reg) == TMR_LAST;
	endproperty
	a_min_time: assert property (p_min_time) // [R8]
		else $error("save finished before its hold time");

	property p_clear;
		$fell(save_busy_reg) |-> !save_req_reg || $past(wr_ctrl_set);
	endproperty
	a_clear: assert property (p_clear) // [R4]
		else $error("request bit not cleared on completion");

	property p_cart_excl;
		cart_prog_en |-> !run_mode && !save_busy_reg;
	endproperty
	a_cart_excl: assert property (p_cart_excl) // [R7] [R17]
		else $error("cartridge write enabled in run or save");

	property p_sw_stop;
		clk_en && pu_done_reg && !halted && sw_s_reg != sw_d_reg
			&& sw_s_reg == ppc_pkg::SW_STOP |=> !run_mode;
	endproperty
	a_sw_stop: assert property (p_sw_stop) // [R20]
		else $error("stop switch did not halt");

	property p_host_refused;
		clk_en && wr_mode && sw_s_reg == ppc_pkg::SW_STOP && !run_reg
			|=> !run_mode;
	endproperty
	a_host_refused: assert property (p_host_refused) // [R22]
		else $error("host run accepted at stop switch");

	property p_pu_mode;
		$rose(pu_done_reg) |-> run_reg == ($past(sw_s_reg) == ppc_pkg::SW_RUN);
	endproperty
	a_pu_mode: assert property (p_pu_mode) // [R21]
		else $error("wrong mode after power-up");

	property p_run_late;
		$rose(run_reg) |-> $past(pu_reg) == PU_DONE;
	endproperty
	a_run_late: assert property (p_run_late) // [R23]
		else $error("run entered before power-up sequence");

	property p_reject;
		clk_en && pu_reg == PU_CART_CHK && settle_reg == 2'h3
			&& cp_s_reg && cart_model > MODEL_LEVEL
			&& !(pf_s_reg && !pf_d_reg)
			|=> cart_error && pu_reg == PU_BLOCKS;
	endproperty
	a_reject: assert property (p_reject) // [R19]
		else $error("higher-model cartridge not rejected");

endmodule

`default_nettype wire

/* core/ppc_pkg.sv */
package ppc_pkg;

	// ----------------------------------------------------------------
	// register map (index, byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int         APB_AW        = 10;
	localparam logic [7:0] SAVE_CTRL_IDX = 8'h1F;
	localparam logic [7:0] SAVE_ADDR_IDX = 8'h20;
	localparam logic [7:0] MODE_IDX      = 8'h21;
	localparam logic [7:0] RETAIN_IDX    = 8'h22;
	localparam logic [7:0] PEEK_IDX      = 8'h23;

	// ----------------------------------------------------------------
	// field positions and codes
	// ----------------------------------------------------------------
	localparam int         REQ_BIT       = 7;
	localparam logic [1:0] SIZE_BYTE     = 2'h1;
	localparam logic [1:0] SIZE_WORD     = 2'h2;
	localparam logic [1:0] SIZE_DWORD    = 2'h3;
	localparam int         MODE_RUN_BIT  = 0;
	localparam int         MODE_STOP_BIT = 1;
	localparam int         MODE_CART_BIT = 2;
	localparam int         MODE_SW_LSB   = 4;
	localparam int         MODE_PU_BIT   = 8;
	localparam int         MODE_LOST_BIT = 9;
	localparam int         MODE_CERR_BIT = 10;
	localparam int         MODE_BUSY_BIT = 11;
	localparam logic [1:0] SW_STOP       = 2'h0;
	localparam logic [1:0] SW_REMOTE     = 2'h1;
	localparam logic [1:0] SW_RUN        = 2'h2;
	localparam int         MB_BYTES      = 14;
	localparam int         NV_AW         = 10;
	localparam int         NV_DW         = 8;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [13:0] RETAIN_RST    = 14'h0000;
	localparam logic [15:0] SAVE_ADDR_RST = 16'h0000;
	localparam logic [1:0]  SAVE_SIZE_RST = 2'h0;
	localparam int          SAVE_TIME_MS  = 10;
	localparam int          CLK_KHZ       = 200000;
	localparam int          SAVE_CYCLES   = SAVE_TIME_MS * CLK_KHZ;
	localparam int          TMR_W         = 24;

	typedef enum logic [3:0] {
		OP_NONE, OP_CART_PROG, OP_CART_DB, OP_CLEAR_V, OP_INIT_V,
		OP_CART_SYS, OP_CLEAR_RET, OP_LOAD_BLOCKS, OP_KEEP_RELOAD,
		OP_ZERO_ALL, OP_RESTORE_MB, OP_SAVE_MB
	} ppc_op_t;

endpackage

/* verification/ppc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----
// variable memory and memory-op executor beside the controller
// ----
module ppc_far_model (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  key,
	input  wire logic [3:0]  dly,
	input  wire logic [15:0] vmem_addr,
	input  wire logic        vmem_rd,
	output logic      [7:0]  vmem_rdata,
	input  wire logic        op_start,
	output logic             op_done
);
	logic [4:0] cnt_reg;

	// byte valid only in the cycle after a fetch, churns otherwise
	always_ff @(posedge core_clk) begin
		if (srst) begin
			vmem_rdata <= 8'hA5;
		end else if (vmem_rd) begin
			vmem_rdata <= vmem_addr[7:0] ^ key;
		end else begin
			vmem_rdata <= ~vmem_rdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_reg <= 5'h0;
		end else if (op_start) begin
			cnt_reg <= {1'h0, dly} + 5'h2;
		end else if (cnt_reg != 5'h0) begin
			cnt_reg <= cnt_reg - 5'h1;
		end
	end

	assign op_done = (cnt_reg == 5'h1);
endmodule

`default_nettype wire

/* verification/tb_plc_persistence_controller.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module tb_plc_persistence_controller;
	localparam int SC = 20;
	logic             core_clk = 0, srst = 1, psel = 0, penable = 0;
	logic             pwrite = 0, pfail = 0, cpres = 1, cdif = 0;
	logic             rkept = 1, chas = 1, scan_end = 0, chk = 0;
	logic             pready, pslverr, op_start, op_done, vmem_rd;
	logic             run_mode, scan_hold, cpe, lost, cerr, pud;
	logic [9:0]       paddr = 0;
	logic [31:0]      pwdata = 0, prdata, r, rnd = 32'h16C53F46;
	logic [1:0]       sw = ppc_pkg::SW_RUN;
	logic [3:0]       cmodel = 4'h1, op_code, dly = 4'h1, eo;
	logic [7:0]       key = 0, vmem_rdata;
	logic [13:0]      op_arg, mask = 0;
	logic [15:0]      vmem_addr, a;
	logic [64:0]      e;
	int               err_count = 0, n_tests = 0, hold = 0, cyc = 0;
	logic [64:0]      rd_q[$];
	ppc_pkg::ppc_op_t op_q[$];

	ppc_persistence_ctrl #(.SAVE_CYC(SC), .MODEL_LEVEL(4'h2)) dut (
		.core_clk, .srst, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .mode_sw_pin(sw),
		.power_fail_pin(pfail), .cart_present_pin(cpres),
		.cart_differs(cdif), .cart_has_prog(chas), .cart_has_data(chas),
		.cart_has_sys(chas), .cart_model(cmodel), .ram_kept(rkept),
		.scan_end, .vmem_addr, .vmem_rd, .vmem_rdata, .op_code, .op_start,
		.op_arg, .op_done, .run_mode, .scan_hold, .cart_prog_en(cpe),
		.data_lost_flag(lost), .cart_error(cerr), .powerup_done(pud));
	ppc_far_model far (.core_clk, .srst, .key, .dly, .vmem_addr,
		.vmem_rd, .vmem_rdata, .op_start, .op_done);

	always #2.5 core_clk = ~core_clk;

	// ----
	// helpers
	// ----
	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [9:0] ad,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		chk <= 1'h0;
	endtask

	task automatic rdc(input logic [9:0] ad, input logic [31:0] ex, m,
		input logic er);
		rd_q.push_back({er, m, ex});
		chk <= 1'h1;
		apb(1'h0, ad, 32'h0);
	endtask

	task automatic rst();
		srst <= 1'h1;
		repeat (10) @(posedge core_clk);
		srst <= 1'h0;
		for (int i = 0; i < 600 && pud !== 1'h1; i++) @(posedge core_clk);
		repeat (2) @(posedge core_clk);
		`CHK("ops_left", 0, op_q.size())
	endtask

	task automatic save(input logic [1:0] s);
		rnd = nx(rnd);
		key <= rnd[7:0];
		apb(1'h1, 10'h080, {16'h0, a});
		apb(1'h1, 10'h07C, {24'h0, 1'h1, 5'h0, s});
		rdc(10'h07C, 32'h80, 32'h80, 1'h0);
		hold = 0;
		scan_end <= 1'h1;
		@(posedge core_clk);
		scan_end <= 1'h0;
		r = 32'h80;
		for (int i = 0; i < 99 && r[7]; i++) apb(1'h0, 10'h07C, 32'h0);
		`CHK("request", 1'h0, r[7])
		`CHK("hold", 1'h1, hold >= SC)
		`CHK("cart_prog_en", 1'h0, cpe)
		for (int i = 0; i < (s == 2'h3 ? 4 : s); i++) begin
			apb(1'h1, 10'h08C, {22'h0, 10'(a + 16'(i))});
			repeat (2) @(posedge core_clk);
			rdc(10'h08C, {24'h0, 8'(a + 16'(i)) ^ key}, 32'hFF, 1'h0);
		end
	endtask

	// ----
	// result watcher and hang guard
	// ----
	always @(posedge core_clk) begin
		cyc++;
		if (scan_hold === 1'h1) hold++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
		if (psel && penable && pready && !pwrite && chk) begin
			e = rd_q.pop_front();
			`CHK("prdata", e[31:0], prdata & e[63:32])
			`CHK("pslverr", e[64], pslverr)
		end
		if (op_start === 1'h1) begin
			eo = op_q.pop_front();
			`CHK("op_code", eo, op_code)
			if (eo == ppc_pkg::OP_SAVE_MB) `CHK("op_arg", mask, op_arg)
		end
	end

	initial begin
		op_q = {ppc_pkg::OP_LOAD_BLOCKS, ppc_pkg::OP_KEEP_RELOAD};
		rst();
		`CHK("run_mode", 1'h1, run_mode)
		rdc(10'h084, 32'h121, 32'h131, 1'h0);
		rdc(10'h3FC, 32'h0, 32'hFFFFFFFF, 1'h1);
		$display("end of test powerup");
		rnd = nx(rnd);
		a = rnd[15:0];
		for (int s = 3; s > 0; s--) save(2'(s));
		$display("end of test save");
		sw <= ppc_pkg::SW_STOP;
		repeat (6) @(posedge core_clk);
		`CHK("run_mode", 1'h0, run_mode)
		apb(1'h1, 10'h084, 32'h5);
		repeat (3) @(posedge core_clk);
		`CHK("run_mode", 1'h0, run_mode)
		`CHK("cart_prog_en", 1'h1, cpe)
		sw <= ppc_pkg::SW_REMOTE;
		repeat (6) @(posedge core_clk);
		`CHK("run_mode", 1'h0, run_mode)
		apb(1'h1, 10'h084, 32'h5);
		repeat (3) @(posedge core_clk);
		`CHK("run_mode", 1'h1, run_mode)
		`CHK("cart_prog_en", 1'h0, cpe)
		$display("end of test mode");
		rnd = nx(rnd);
		mask = rnd[13:0] | 14'h1;
		apb(1'h1, 10'h088, {18'h0, mask});
		rdc(10'h088, {18'h0, mask}, 32'hFFFFFFFF, 1'h0);
		op_q = {ppc_pkg::OP_SAVE_MB};
		pfail <= 1'h1;
		repeat (30) @(posedge core_clk);
		`CHK("run_mode", 1'h0, run_mode)
		`CHK("ops_left", 0, op_q.size())
		$display("end of test power loss");
		pfail <= 1'h0;
		rkept <= 1'h0;
		cdif <= 1'h1;
		dly <= rnd[19:16];
		op_q = {ppc_pkg::OP_CART_PROG, ppc_pkg::OP_CART_DB,
			ppc_pkg::OP_CLEAR_V, ppc_pkg::OP_INIT_V, ppc_pkg::OP_CART_SYS,
			ppc_pkg::OP_CLEAR_RET, ppc_pkg::OP_LOAD_BLOCKS,
			ppc_pkg::OP_ZERO_ALL, ppc_pkg::OP_INIT_V};
		rst();
		`CHK("data_lost", 1'h1, lost)
		apb(1'h1, 10'h084, 32'h200);
		@(posedge core_clk);
		`CHK("data_lost_clear", 1'h0, lost)
		`CHK("run_mode", 1'h0, run_mode)
		`CHK("cart_error", 1'h0, cerr)
		$display("end of test cartridge");
		cmodel <= 4'h3;
		rkept <= 1'h1;
		op_q = {ppc_pkg::OP_LOAD_BLOCKS, ppc_pkg::OP_KEEP_RELOAD};
		rst();
		`CHK("cart_error", 1'h1, cerr)
		$display("end of test model");
		summarize();
	end
endmodule

`default_nettype wire
